/* File: rtl/timekeep_defs.vh */
`ifndef TIMEKEEP_DEFS_VH
`define TIMEKEEP_DEFS_VH
// verbosity levels
`define VERB_DISABLE        2'h0
`define VERB_FATAL_ONLY     2'h1
`define VERB_PROGRESS       2'h2
`define VERB_SERVICE        2'h3
// log message classes
`define LOGC_FATAL          2'h0
`define LOGC_PROGRESS       2'h1
`define LOGC_USER           2'h2
`define LOGC_POWERON        2'h3
// supply status codes
`define SUPPLY_MAINS        2'h0
`define SUPPLY_AUX_DC       2'h1
`define SUPPLY_BATTERY      2'h2
`define SUPPLY_LOW          2'h3
// command codes
`define CMD_VERBOSITY       4'h1
`define CMD_DISPLAY         4'h2
`define CMD_TIME_SET        4'h3
`define CMD_DAY_SET         4'h4
`define CMD_LEAP_LEN        4'h5
`define CMD_LEAP_DAY        4'h6
`define CMD_LEAP_SWITCH     4'h7
`define CMD_SLEW            4'h8
`define CMD_IDLE_SWITCH     4'h9
`define CMD_DIAG_TEST       4'hA
// limits
`define MAX_HOUR            5'h17
`define MAX_MINSEC          6'h3B
`define MAX_DAY             17'h1869F
`define MAX_LEAP_DAY        20'hF423F
`define MAX_TEST_SEL        5'h11
`define ALL_TESTS_SEL       5'h1F
`define TEST_COUNT          5'h12
// slew: 0.5 s in 50 ns steps
`define SLEW_STEP_NS        50
`define SLEW_LIMIT_NS       500000000
`define SLEW_LIMIT_STEPS    24'h989680
// error codes
`define ERR_NONE            9'h000
`define ERR_NOT_STANDBY     9'h0CB
`define ERR_NOT_REMOTE      9'h0C9
`define ERR_RANGE           9'h0DE
// reset values
`define RST_VERBOSITY       2'h2
`define RST_LEAP_LEN        7'h3C
`endif

/* File: rtl/log_echo_filter.v */
`default_nettype none
`include "timekeep_defs.vh"
module log_echo_filter (
	input  wire       i_clk,
	input  wire       i_rst_b,
	input  wire [1:0] i_level,
	input  wire       i_msg_valid,
	input  wire [1:0] i_msg_class,
	output reg        o_store,
	output reg        o_echo
);
	reg pass;
	always @* begin
		case (i_level)
			`VERB_DISABLE:    pass = 1'b0;
			`VERB_FATAL_ONLY: pass = (i_msg_class == `LOGC_FATAL);
			`VERB_PROGRESS:   pass = (i_msg_class != `LOGC_POWERON);
			default:          pass = 1'b1;
		endcase
	end
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_store <= 1'b0;
			o_echo  <= 1'b0;
		end else begin
			o_store <= i_msg_valid; // RULE_02
			o_echo  <= i_msg_valid & pass; // RULE_01
		end
	end
endmodule // log_echo_filter
`default_nettype wire

/* File: rtl/diag_sequencer.v */
`default_nettype none
`include "timekeep_defs.vh"
module diag_sequencer (
	input  wire       i_clk,
	input  wire       i_rst_b,
	input  wire       i_start,
	input  wire [4:0] i_sel,
	input  wire       i_test_done,
	input  wire       i_test_fail,
	output reg        o_test_go,
	output reg  [4:0] o_test_id,
	output reg        o_busy,
	output reg        o_done,
	output reg        o_fail
);
	localparam S_IDLE = 2'h0;
	localparam S_GO   = 2'h1;
	localparam S_WAIT = 2'h2;
	reg [1:0] state_reg;
	reg       all_reg;
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= S_IDLE;
			all_reg   <= 1'b0;
			o_test_go <= 1'b0;
			o_test_id <= 5'h00;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_fail    <= 1'b0;
		end else begin
			o_test_go <= 1'b0;
			o_done    <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (i_start) begin
						all_reg   <= (i_sel == `ALL_TESTS_SEL); // RULE_06
						o_test_id <= (i_sel == `ALL_TESTS_SEL) ? 5'h00 : i_sel;
						o_fail    <= 1'b0;
						o_busy    <= 1'b1;
						state_reg <= S_GO;
					end
				end
				S_GO: begin
					o_test_go <= 1'b1;
					state_reg <= S_WAIT;
				end
				S_WAIT: begin
					if (i_test_done) begin
						if (i_test_fail)
							o_fail <= 1'b1; // RULE_07
						if (all_reg && o_test_id != `MAX_TEST_SEL) begin
							o_test_id <= o_test_id + 5'h01; // RULE_06
							state_reg <= S_GO;
						end else begin
							o_busy    <= 1'b0;
							o_done    <= 1'b1;
							state_reg <= S_IDLE;
						end
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule // diag_sequencer
`default_nettype wire

/* File: rtl/precision_timekeeping_control.v */
// How it works
// RULE_01 - serial echo filtered by level: none, fatal, progress/user, plus power-on
// RULE_02 - every log message is stored regardless of echo level
// RULE_03 - verbosity query answers one of four level codes
// RULE_04 - supply status reported as mains, aux dc, battery or low code
// RULE_05 - diagnostic runs only in standby or fatal state, else error 203
// RULE_06 - test selectors 0..17 run one test; all-ones selector runs all eighteen
// RULE_07 - test result is 0 on pass, 1 if any selected test fails
// RULE_08 - display lit only when enabled and time set; query reports same
// RULE_09 - setting commands execute only in remote mode
// RULE_10 - time set takes hours, minutes, seconds, limits 23, 59, 59
// RULE_11 - general reset command leaves time, day, leap, slew, standby unchanged
// RULE_12 - day number 0..99999 loads the running day counter
// RULE_13 - day counter starts at zero and increments at midnight rollover
// RULE_14 - leap minute length stored; writing it reschedules a pending leap
// RULE_15 - leap day 0..999999; writing it reschedules a pending leap
// RULE_16 - switching leap on schedules with stored values; off cancels
// RULE_17 - leap query answers 1 while pending, else 0
// RULE_18 - leap length query gives pending length, else last stored
// RULE_19 - leap day query gives pending day, else max of stored and current
// RULE_20 - epoch slew is a one-time phase step, +-0.5 s, 50 ns steps
// RULE_21 - standby enable enters standby; disable resumes when permitted
// RULE_22 - standby query answers 1 in standby, else 0
// RULE_23 - seconds advance on 1 pps; carry to minutes and hours, 23 wraps; a tick in the cycle of a valid time or day set is dropped
// RULE_24 - rejected gated commands leave settings unchanged and queue an error
`default_nettype none
`include "timekeep_defs.vh"
module precision_timekeeping_control (
	input  wire        I_CLK,
	input  wire        I_RST_B,
	input  wire        i_remote,
	input  wire        i_cmd_valid,
	input  wire [3:0]  i_cmd_code,
	input  wire [23:0] i_cmd_arg,
	input  wire [5:0]  i_cmd_min,
	input  wire [5:0]  i_cmd_sec,
	input  wire        i_general_reset,
	input  wire        i_pps_tick,
	input  wire        i_fatal_state,
	input  wire        i_resume_ok,
	input  wire [1:0]  i_supply_code,
	input  wire        i_log_valid,
	input  wire [1:0]  i_log_class,
	input  wire        i_test_done,
	input  wire        i_test_fail,
	output reg  [4:0]  o_hours,
	output reg  [5:0]  o_minutes,
	output reg  [5:0]  o_seconds,
	output reg  [16:0] o_day_number,
	output reg  [1:0]  o_verbosity,
	output reg  [1:0]  o_supply_status,
	output reg         o_display_lit,
	output reg         o_leap_pending,
	output reg  [6:0]  o_leap_len_answer,
	output reg  [19:0] o_leap_day_answer,
	output reg         o_slew_strobe,
	output reg  [23:0] o_slew_steps,
	output reg         o_standby,
	output reg         o_log_store,
	output reg         o_log_echo,
	output reg         o_test_go,
	output reg  [4:0]  o_test_id,
	output reg         o_test_result_valid,
	output reg         o_test_result,
	output reg         o_err_valid,
	output reg  [8:0]  o_err_code
);
	reg        disp_en_reg;
	reg        time_set_reg;
	reg [6:0]  leap_len_reg;
	reg [19:0] leap_day_reg;
	reg [6:0]  pend_len_reg;
	reg [19:0] pend_day_reg;
	reg        idle_req_reg;
	reg        diag_start;
	reg [4:0]  diag_sel;
	wire       store_w;
	wire       echo_w;
	wire       seq_go;
	wire [4:0] seq_id;
	wire       seq_busy;
	wire       seq_done;
	wire       seq_fail;

	wire gated = (i_cmd_code == `CMD_VERBOSITY) || (i_cmd_code == `CMD_DISPLAY) ||
		(i_cmd_code == `CMD_TIME_SET) || (i_cmd_code == `CMD_DAY_SET) ||
		(i_cmd_code == `CMD_SLEW) || (i_cmd_code == `CMD_IDLE_SWITCH);
	wire accept = i_cmd_valid & (~gated | i_remote); // RULE_09
	wire [23:0] slew_mag = i_cmd_arg[23] ? (~i_cmd_arg + 24'h000001) : i_cmd_arg;
	wire slew_ok = (slew_mag <= `SLEW_LIMIT_STEPS);
	wire time_ok = (i_cmd_arg[4:0] <= `MAX_HOUR) && (i_cmd_min <= `MAX_MINSEC) &&
		(i_cmd_sec <= `MAX_MINSEC);
	wire sec_wrap  = (o_seconds == `MAX_MINSEC);
	wire min_wrap  = sec_wrap && (o_minutes == `MAX_MINSEC);
	wire midnight  = min_wrap && (o_hours == `MAX_HOUR);
	wire [19:0] cur_day = {3'h0, o_day_number};

	log_echo_filter u_log (
		.i_clk       (I_CLK),
		.i_rst_b     (I_RST_B),
		.i_level     (o_verbosity),
		.i_msg_valid (i_log_valid),
		.i_msg_class (i_log_class),
		.o_store     (store_w),
		.o_echo      (echo_w)
	);

	diag_sequencer u_diag (
		.i_clk       (I_CLK),
		.i_rst_b     (I_RST_B),
		.i_start     (diag_start),
		.i_sel       (diag_sel),
		.i_test_done (i_test_done),
		.i_test_fail (i_test_fail),
		.o_test_go   (seq_go),
		.o_test_id   (seq_id),
		.o_busy      (seq_busy),
		.o_done      (seq_done),
		.o_fail      (seq_fail)
	);

	// error queue entry and diagnostic launch
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_err_valid <= 1'b0;
			o_err_code  <= `ERR_NONE;
			diag_start  <= 1'b0;
			diag_sel    <= 5'h00;
		end else begin
			o_err_valid <= 1'b0;
			diag_start  <= 1'b0;
			if (i_cmd_valid && gated && !i_remote) begin
				o_err_valid <= 1'b1; // RULE_24
				o_err_code  <= `ERR_NOT_REMOTE;
			end else if (accept && i_cmd_code == `CMD_DIAG_TEST) begin
				if (!(o_standby || i_fatal_state)) begin
					o_err_valid <= 1'b1; // RULE_05
					o_err_code  <= `ERR_NOT_STANDBY;
				end else if ((i_cmd_arg[4:0] > `MAX_TEST_SEL &&
					i_cmd_arg[4:0] != `ALL_TESTS_SEL) || seq_busy) begin
					o_err_valid <= 1'b1;
					o_err_code  <= `ERR_RANGE;
				end else begin
					diag_start <= 1'b1; // RULE_05
					diag_sel   <= i_cmd_arg[4:0]; // RULE_06
				end
			end else if (accept && ((i_cmd_code == `CMD_TIME_SET && !time_ok) ||
				(i_cmd_code == `CMD_DAY_SET && i_cmd_arg[16:0] > `MAX_DAY) ||
				(i_cmd_code == `CMD_LEAP_DAY && i_cmd_arg[19:0] > `MAX_LEAP_DAY) ||
				(i_cmd_code == `CMD_SLEW && !slew_ok))) begin
				o_err_valid <= 1'b1;
				o_err_code  <= `ERR_RANGE;
			end
		end
	end

	// time of day and day counter; the general reset input is never looked at here
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_hours      <= 5'h00;
			o_minutes    <= 6'h00;
			o_seconds    <= 6'h00;
			o_day_number <= 17'h00000; // RULE_13
			time_set_reg <= 1'b0;
		end else if (accept && i_cmd_code == `CMD_TIME_SET && time_ok) begin
			o_hours      <= i_cmd_arg[4:0]; // RULE_10
			o_minutes    <= i_cmd_min;
			o_seconds    <= i_cmd_sec;
			time_set_reg <= 1'b1;
		end else if (accept && i_cmd_code == `CMD_DAY_SET &&
			i_cmd_arg[16:0] <= `MAX_DAY) begin
			o_day_number <= i_cmd_arg[16:0]; // RULE_12
		end else if (i_pps_tick) begin
			o_seconds <= sec_wrap ? 6'h00 : o_seconds + 6'h01; // RULE_23
			if (sec_wrap)
				o_minutes <= min_wrap ? 6'h00 : o_minutes + 6'h01;
			if (min_wrap)
				o_hours <= midnight ? 5'h00 : o_hours + 5'h01;
			if (midnight)
				o_day_number <= o_day_number + 17'h00001; // RULE_13
		end
	end

	// leap second scheduling; ungated because these commands carry no mode condition
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			leap_len_reg   <= `RST_LEAP_LEN;
			leap_day_reg   <= 20'h00000;
			pend_len_reg   <= `RST_LEAP_LEN;
			pend_day_reg   <= 20'h00000;
			o_leap_pending <= 1'b0;
		end else if (accept) begin
			case (i_cmd_code)
				`CMD_LEAP_LEN: begin
					leap_len_reg <= i_cmd_arg[6:0]; // RULE_14
					if (o_leap_pending)
						pend_len_reg <= i_cmd_arg[6:0]; // RULE_14
				end
				`CMD_LEAP_DAY: begin
					if (i_cmd_arg[19:0] <= `MAX_LEAP_DAY) begin
						leap_day_reg <= i_cmd_arg[19:0]; // RULE_15
						if (o_leap_pending)
							pend_day_reg <= i_cmd_arg[19:0]; // RULE_15
					end
				end
				`CMD_LEAP_SWITCH: begin
					o_leap_pending <= i_cmd_arg[0]; // RULE_16
					if (i_cmd_arg[0]) begin
						pend_len_reg <= leap_len_reg; // RULE_16
						pend_day_reg <= leap_day_reg;
					end
				end
				default: o_leap_pending <= o_leap_pending; // RULE_17
			endcase
		end
	end

	// settings, standby and slew
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_verbosity   <= `RST_VERBOSITY;
			disp_en_reg   <= 1'b0;
			idle_req_reg  <= 1'b0;
			o_standby     <= 1'b0; // RULE_22
			o_slew_strobe <= 1'b0;
			o_slew_steps  <= 24'h000000;
		end else begin
			o_slew_strobe <= 1'b0;
			if (accept && i_cmd_code == `CMD_VERBOSITY)
				o_verbosity <= i_cmd_arg[1:0]; // RULE_03
			if (accept && i_cmd_code == `CMD_DISPLAY)
				disp_en_reg <= i_cmd_arg[0];
			if (accept && i_cmd_code == `CMD_IDLE_SWITCH)
				idle_req_reg <= i_cmd_arg[0];
			if (accept && i_cmd_code == `CMD_SLEW && slew_ok) begin
				o_slew_strobe <= 1'b1; // RULE_20
				o_slew_steps  <= i_cmd_arg;
			end
			// leaving standby waits for the plant to permit normal running
			if (idle_req_reg)
				o_standby <= 1'b1; // RULE_21
			else if (i_resume_ok)
				o_standby <= 1'b0; // RULE_21
		end
	end

	// status answers, all registered
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_supply_status     <= `SUPPLY_MAINS;
			o_display_lit       <= 1'b0;
			o_leap_len_answer   <= `RST_LEAP_LEN;
			o_leap_day_answer   <= 20'h00000;
			o_log_store         <= 1'b0;
			o_log_echo          <= 1'b0;
			o_test_go           <= 1'b0;
			o_test_id           <= 5'h00;
			o_test_result_valid <= 1'b0;
			o_test_result       <= 1'b0;
		end else begin
			o_supply_status   <= i_supply_code; // RULE_04
			o_display_lit     <= disp_en_reg & time_set_reg; // RULE_08
			o_leap_len_answer <= o_leap_pending ? pend_len_reg : leap_len_reg; // RULE_18
			if (o_leap_pending)
				o_leap_day_answer <= pend_day_reg; // RULE_19
			else
				o_leap_day_answer <= (leap_day_reg > cur_day) ? leap_day_reg : cur_day;
			o_log_store         <= store_w; // RULE_02
			o_log_echo          <= echo_w; // RULE_01
			o_test_go           <= seq_go;
			o_test_id           <= seq_id;
			o_test_result_valid <= seq_done;
			if (seq_done)
				o_test_result <= seq_fail; // RULE_07
		end
	end

	wire unused_ok = i_general_reset; // RULE_11
endmodule // precision_timekeeping_control
`default_nettype wire

/* File: sim/timekeep_monitor.sv */
`default_nettype none
module timekeep_monitor (
	input wire logic        I_CLK,
	input wire logic        I_RST_B,
	input wire logic        i_remote,
	input wire logic        i_cmd_valid,
	input wire logic [3:0]  i_cmd_code,
	input wire logic [23:0] i_cmd_arg,
	input wire logic        i_pps_tick,
	input wire logic        i_log_valid,
	input wire logic        i_general_reset,
	input wire logic        i_fatal_state,
	input wire logic [4:0]  o_hours,
	input wire logic [5:0]  o_minutes,
	input wire logic [5:0]  o_seconds,
	input wire logic [16:0] o_day_number,
	input wire logic        o_standby,
	input wire logic        o_log_store,
	input wire logic        o_slew_strobe,
	input wire logic [23:0] o_slew_steps,
	input wire logic        o_err_valid,
	input wire logic [8:0]  o_err_code,
	input wire logic        o_test_go
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	// the top day is left out: its wrap is not defined
	sequence at_midnight;
		i_pps_tick && !i_cmd_valid && o_hours == 5'h17 && o_minutes == 6'h3B
			&& o_seconds == 6'h3B && o_day_number != 17'h1869F;
	endsequence
	sequence gated_local;
		i_cmd_valid && !i_remote
			&& i_cmd_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
	endsequence
	day_rollover_a: assert property (at_midnight |=> o_hours == 5'h00
		&& o_day_number == $past(o_day_number) + 17'h00001) else $error("no midnight carry");
	sec_advance_a: assert property (i_pps_tick && !i_cmd_valid && o_seconds < 6'h3B
		|=> o_seconds == $past(o_seconds) + 6'h01) else $error("seconds did not advance");
	remote_gate_a: assert property (gated_local |=> o_err_valid
		&& o_err_code == 9'h0C9 && $stable(o_standby)) else $error("local command taken");
	diag_refuse_a: assert property (i_cmd_valid && i_cmd_code == 4'hA
		&& !o_standby && !i_fatal_state |=> (o_err_valid && o_err_code == 9'h0CB)
		##1 !o_test_go [*4]) else $error("diag ran outside standby");
	standby_enter_a: assert property (i_cmd_valid && i_remote
		&& i_cmd_code == 4'h9 && i_cmd_arg[0] |=> ##1 o_standby) else $error("no standby");
	log_store_a: assert property (i_log_valid |-> ##2 o_log_store)
		else $error("log not stored");
	reset_keep_a: assert property (i_general_reset && !i_cmd_valid && !i_pps_tick
		|=> $stable(o_hours) && $stable(o_day_number) && $stable(o_standby))
		else $error("general reset changed state");
	slew_event_a: assert property (i_cmd_valid && i_remote && i_cmd_code == 4'h8
		|=> o_slew_strobe && o_slew_steps == $past(i_cmd_arg)) else $error("slew lost");
endmodule // timekeep_monitor
`default_nettype wire

/* File: sim/remote_host_model.sv */
`default_nettype none
module remote_host_model (
	input  wire logic        clk,
	output var  logic        remote,
	output var  logic        cmd_valid,
	output var  logic [3:0]  cmd_code,
	output var  logic [23:0] cmd_arg,
	output var  logic [5:0]  cmd_min,
	output var  logic [5:0]  cmd_sec
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{remote, cmd_valid, cmd_code, cmd_arg, cmd_min, cmd_sec} = '0;
	end
	task automatic mode(input logic on);
		remote = on;
	endtask
	task automatic send(input logic [3:0] c, input logic [23:0] a, input logic [5:0] m, s);
		{cmd_code, cmd_arg, cmd_min, cmd_sec} = {c, a, m, s};
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		// released lines turn over so a stale sample cannot pass
		{cmd_arg, cmd_min, cmd_sec} = ~{a, m, s};
	endtask
endmodule // remote_host_model
`default_nettype wire

/* File: sim/precision_timekeeping_control_tb_top.sv */
`default_nettype none
module precision_timekeeping_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CLK, I_RST_B, i_general_reset, i_pps_tick, i_fatal_state, i_resume_ok;
	logic i_log_valid, i_test_done, i_test_fail;
	logic [1:0] i_supply_code, i_log_class;
	logic [4:0] fail_id, last_id;
	wire i_remote, i_cmd_valid;
	wire [3:0] i_cmd_code;
	wire [23:0] i_cmd_arg, o_slew_steps;
	wire [5:0] i_cmd_min, i_cmd_sec, o_minutes, o_seconds;
	wire [4:0] o_hours, o_test_id;
	wire [16:0] o_day_number;
	wire [1:0] o_verbosity, o_supply_status;
	wire o_display_lit, o_leap_pending, o_slew_strobe, o_standby, o_log_store, o_log_echo;
	wire o_test_go, o_test_result_valid, o_test_result, o_err_valid;
	wire [6:0] o_leap_len_answer;
	wire [19:0] o_leap_day_answer;
	wire [8:0] o_err_code;
	int miscompares, checks_done, go_count;
	remote_host_model host (.clk(I_CLK), .remote(i_remote), .cmd_valid(i_cmd_valid),
		.cmd_code(i_cmd_code), .cmd_arg(i_cmd_arg), .cmd_min(i_cmd_min), .cmd_sec(i_cmd_sec));
	precision_timekeeping_control DUT (.I_CLK, .I_RST_B, .i_remote, .i_cmd_valid, .i_cmd_code,
		.i_cmd_arg, .i_cmd_min, .i_cmd_sec, .i_general_reset, .i_pps_tick, .i_fatal_state,
		.i_resume_ok, .i_supply_code, .i_log_valid, .i_log_class, .i_test_done, .i_test_fail,
		.o_hours, .o_minutes, .o_seconds, .o_day_number, .o_verbosity, .o_supply_status,
		.o_display_lit, .o_leap_pending, .o_leap_len_answer, .o_leap_day_answer,
		.o_slew_strobe, .o_slew_steps, .o_standby, .o_log_store, .o_log_echo, .o_test_go,
		.o_test_id, .o_test_result_valid, .o_test_result, .o_err_valid, .o_err_code);
	always #5 I_CLK = ~I_CLK;
	// test hardware answers one cycle after each start
	always @(posedge I_CLK) begin
		i_test_done <= o_test_go;
		i_test_fail <= o_test_go ? o_test_id === fail_id : ~i_test_fail;
		if (o_test_go === 1'b1) begin
			go_count <= go_count + 1;
			last_id <= o_test_id;
		end
	end
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge I_CLK);
		#1;
	endtask
	task automatic cmd(input logic [3:0] c, input logic [23:0] a);
		host.send(c, a, 6'h00, 6'h00);
	endtask
	task automatic pps();
		i_pps_tick = 1'b1;
		cyc(1);
		i_pps_tick = 1'b0;
	endtask
	task automatic t_time();
		host.mode(1'b1);
		cmd(4'h2, 24'h1);
		cyc(1);
		chk("lit unset", o_display_lit, 24'h0);
		cmd(4'h4, 24'h11);
		chk("day", o_day_number, 24'h11);
		host.send(4'h3, 24'h17, 6'h3B, 6'h3A);
		chk("hour", o_hours, 24'h17);
		cyc(1);
		chk("lit", o_display_lit, 24'h1);
		pps();
		chk("sec", o_seconds, 24'h3B);
		pps();
		chk("wrap", {o_hours, o_minutes, o_seconds}, 24'h0);
		chk("day inc", o_day_number, 24'h12);
	endtask
	task automatic t_refuse();
		host.mode(1'b0);
		host.send(4'h3, 24'h1, 6'h2, 6'h3);
		chk("local", {o_err_valid, o_err_code}, 24'h2C9);
		chk("kept", o_hours, 24'h0);
		host.mode(1'b1);
		host.send(4'h3, 24'h18, 6'h2, 6'h3);
		chk("hour range", {o_err_valid, o_err_code}, 24'h2DE);
		cmd(4'h4, 24'h186A0);
		chk("day range", {o_err_valid, o_day_number}, 24'h20012);
		cmd(4'h4, 24'h1869F);
		chk("day max", o_day_number, 24'h1869F);
	endtask
	task automatic t_leap();
		cyc(1);
		chk("leap day cur", o_leap_day_answer, 24'h1869F);
		cmd(4'h5, 24'h3D);
		cmd(4'h6, 24'h7A120);
		cmd(4'h7, 24'h1);
		chk("pending", o_leap_pending, 24'h1);
		cyc(1);
		chk("leap len", o_leap_len_answer, 24'h3D);
		chk("leap day", o_leap_day_answer, 24'h7A120);
		cmd(4'h5, 24'h3E);
		cyc(1);
		chk("resched", {o_leap_pending, o_leap_len_answer}, 24'hBE);
		cmd(4'h6, 24'hF4240);
		chk("leap range", {o_err_valid, o_err_code}, 24'h2DE);
		cmd(4'h7, 24'h0);
		cyc(1);
		chk("cancel", {o_leap_pending, o_leap_day_answer}, 24'h7A120);
	endtask
	task automatic run_diag(input logic [4:0] sel, input int n, input logic res);
		go_count = 0;
		cmd(4'hA, {19'h0, sel});
		for (int k = 0; k < 400 && o_test_result_valid !== 1'b1; k++) cyc(1);
		chk("result", {o_test_result_valid, o_test_result}, {1'b1, res});
		chk("tests", {go_count[18:0], last_id}, {n[18:0], (sel == 5'h1F) ? 5'h11 : sel});
	endtask
	task automatic t_diag();
		fail_id = 5'h1E;
		cmd(4'hA, 24'h3);
		chk("not idle", {o_err_valid, o_err_code}, 24'h2CB);
		cmd(4'h9, 24'h1);
		chk("not yet", o_standby, 24'h0);
		cyc(1);
		chk("standby", o_standby, 24'h1);
		run_diag(5'h03, 1, 1'b0);
		fail_id = 5'h11;
		run_diag(5'h1F, 18, 1'b1);
		cmd(4'hA, 24'h12);
		chk("bad sel", {o_err_valid, o_err_code}, 24'h2DE);
		cmd(4'h9, 24'h0);
		cyc(1);
		chk("held", o_standby, 24'h1);
		i_resume_ok = 1'b1;
		cyc(2);
		chk("resumed", o_standby, 24'h0);
	endtask
	task automatic t_log();
		for (int l = 0; l < 4; l++) begin
			cmd(4'h1, l);
			chk("level", o_verbosity, l);
			for (int c = 0; c < 4; c++) begin
				i_log_class = c[1:0];
				i_log_valid = 1'b1;
				cyc(1);
				i_log_valid = 1'b0;
				cyc(1);
				chk("store", o_log_store, 24'h1);
				chk("echo", o_log_echo, l == 3 || l == 2 && c != 3 || l == 1 && c == 0);
			end
		end
	endtask
	task automatic t_misc();
		for (int s = 0; s < 4; s++) begin
			i_supply_code = s[1:0];
			cyc(2);
			chk("supply", o_supply_status, s);
		end
		i_general_reset = 1'b1;
		cyc(1);
		i_general_reset = 1'b0;
		chk("kept", {o_hours, o_day_number}, 24'h1869F);
		cmd(4'h8, 24'hFFFFF6);
		chk("slew", {o_slew_strobe, o_slew_steps[22:0]}, 24'hFFFFF6);
		cyc(1);
		chk("slew once", o_slew_strobe, 24'h0);
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{I_CLK, I_RST_B, i_general_reset, i_pps_tick, i_fatal_state, i_resume_ok} = '0;
		{i_log_valid, i_test_done, i_test_fail, i_supply_code, i_log_class} = '0;
		{fail_id, last_id, miscompares, checks_done, go_count} = '0;
		repeat (4) @(posedge I_CLK);
		#1;
		I_RST_B = 1'b1;
		t_time();
		t_refuse();
		t_leap();
		t_diag();
		t_log();
		t_misc();
		complete_run();
	end
	// the whole run needs under a thousand cycles
	initial begin
		#50000;
		miscompares++;
		complete_run();
	end
endmodule // precision_timekeeping_control_tb_top
bind precision_timekeeping_control timekeep_monitor u_mon (.I_CLK, .I_RST_B, .i_remote,
	.i_cmd_valid, .i_cmd_code, .i_cmd_arg, .i_pps_tick, .i_log_valid, .i_general_reset,
	.i_fatal_state, .o_hours, .o_minutes, .o_seconds, .o_day_number, .o_standby,
	.o_log_store, .o_slew_strobe, .o_slew_steps, .o_err_valid, .o_err_code, .o_test_go);
`default_nettype wire
